// File: tmon_pkg.sv
// Shared constants and types of the three-channel temperature monitor.
// Assumes a single 100 MHz clock domain and an external serial front end.
package tmon_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_MAX_MS = 32;
  localparam int TIMEOUT_CYC_DFLT = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TO_W = 22;

  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_R1 = 2'h1;
  localparam logic [1:0] CH_R2 = 2'h2;

  localparam logic [3:0] AVG_LAST = 4'hf;
  localparam int AVG_SHIFT = 4;

  // Register pointer values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] ADDR_LOCAL = 8'h00;
  localparam logic [7:0] ADDR_REM_HI = 8'h01;
  localparam logic [7:0] ADDR_REM_LO = 8'h10;
  localparam logic [7:0] ADDR_R2_HI = 8'h30;
  localparam logic [7:0] ADDR_R2_LO = 8'h33;
  localparam logic [7:0] ADDR_CFG_RD = 8'h03;
  localparam logic [7:0] ADDR_CFG_WR = 8'h09;
  localparam logic [7:0] ADDR_STAT_A = 8'h02;
  localparam logic [7:0] ADDR_STAT_B = 8'h24;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_TOCTL = 8'h50;
  localparam logic [3:0] LIM_BANK = 4'h4;
  localparam logic [1:0] LIM_HIGH = 2'h0;
  localparam logic [1:0] LIM_LOW = 2'h1;
  localparam logic [1:0] LIM_THERMAL_TRIP_N = 2'h2;
  localparam logic [7:0] LIM_HIGH_RST = 8'h55;
  localparam logic [7:0] LIM_LOW_RST = 8'h00;
  localparam logic [7:0] LIM_THERMAL_TRIP_N_RST = 8'h55;

  // Configuration bits
  localparam int CFG_EXT = 2;
  localparam int CFG_R2SEL = 3;
  localparam int CFG_ALT = 5;
  localparam int CFG_STBY = 6;
  localparam int CFG_MASK = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int TOCTL_EN = 0;
  localparam logic [3:0] RATE_RST = 4'h4;
  localparam logic [3:0] RATE_NOAVG = 4'h8;

  // Per-channel flag positions
  localparam int FL_HIGH = 0;
  localparam int FL_LOW = 1;
  localparam int FL_THERMAL_TRIP_N = 2;
  localparam int FL_OPEN = 3;

  // Result scaling, quarter degrees
  localparam logic signed [15:0] EXT_OFFSET = 16'sh0100;
  localparam logic signed [15:0] BIN_MAX = 16'sh01ff;
  localparam logic signed [15:0] EXT_MAX = 16'sh03ff;
  localparam logic [5:0] LO_PAD = 6'h00;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'h1,
    SQ_CONV = 3'h2,
    SQ_WAIT = 3'h4
  } tmon_seq_t;
endpackage : tmon_pkg

// File: tmon_smp_if.sv
// Sample path between the sequencer and the averaging/format filter.
// Assumes both ends run on the same clock and clock enable.
interface tmon_smp_if;
  logic sampleValid;
  logic signed [11:0] sample;
  logic avgEn;
  logic extRange;
  logic stepDone;
  logic resultValid;
  logic [7:0] resultHi;
  logic [7:0] resultLo;
  modport src (output sampleValid, sample, avgEn, extRange, input stepDone, resultValid, resultHi, resultLo);
  modport flt (input sampleValid, sample, avgEn, extRange, output stepDone, resultValid, resultHi, resultLo);
endinterface : tmon_smp_if

// File: tmon_filter.sv
// Averaging and result formatting for one sample stream.
// Assumes samples are signed quarter degrees and arrive one per request.
module tmon_filter
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  tmon_smp_if.flt smp
);
  import tmon_pkg::*;

  typedef struct packed {
    logic signed [15:0] acc;
    logic [3:0] cnt;
    logic stepDone;
    logic resultValid;
    logic [7:0] hi;
    logic [7:0] lo;
  } tmon_flt_state_t;

  tmon_flt_state_t st_r;
  tmon_flt_state_t st_nxt;
  logic signed [15:0] sext;
  logic signed [15:0] sum;
  logic signed [15:0] scaled;
  logic signed [15:0] maxVal;

  always_comb
  begin
    st_nxt = st_r;
    sext = {{4{smp.sample[11]}}, smp.sample};
    sum = st_r.acc + sext;
    maxVal = smp.extRange ? EXT_MAX : BIN_MAX;
    scaled = (smp.avgEn ? (sum >>> AVG_SHIFT) : sext) + (smp.extRange ? EXT_OFFSET : 16'sh0000);
    st_nxt.stepDone = 1'b0;
    st_nxt.resultValid = 1'b0;
    if (!rst_n)
    begin
      st_nxt = '0;
    end
    else if (smp.sampleValid)
    begin
      st_nxt.stepDone = 1'b1;
      if (!smp.avgEn || st_r.cnt == AVG_LAST)
      begin
        if (scaled < 16'sh0000)
        begin
          scaled = 16'sh0000;
        end
        else if (scaled > maxVal)
        begin
          scaled = maxVal;
        end
        st_nxt.hi = scaled[9:2];
        st_nxt.lo = {scaled[1:0], LO_PAD};
        st_nxt.resultValid = 1'b1;
        st_nxt.acc = '0;
        st_nxt.cnt = '0;
      end
      else
      begin
        st_nxt.acc = sum;
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clkEn)
    begin
      st_r <= st_nxt;
    end
  end

  assign smp.stepDone = st_r.stepDone;
  assign smp.resultValid = st_r.resultValid;
  assign smp.resultHi = st_r.hi;
  assign smp.resultLo = st_r.lo;

  property p_noavg;
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && smp.sampleValid && !smp.avgEn |=> st_r.resultValid;
  endproperty
  a_noavg: assert property (p_noavg) else $error("unaveraged sample gave no result");

  property p_avg_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && smp.sampleValid && smp.avgEn && st_r.cnt != AVG_LAST |=> !st_r.resultValid;
  endproperty
  a_avg_hold: assert property (p_avg_hold) else $error("result before sixteen samples");

  property p_ext;
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && smp.sampleValid && !smp.avgEn && smp.extRange && !smp.sample[11] && smp.sample[10:9] == 2'h0
    |=> st_r.hi == $past(smp.sample[9:2]) + 8'h40;
  endproperty
  a_ext: assert property (p_ext) else $error("extended result not offset by 64");
endmodule : tmon_filter

// File: tmon_monitor.sv
// Sequencer, register file and alarm logic of the temperature monitor.
// Assumes an external serial front end giving pointer/data strobes and an ADC front end.
// Functional notes
// - Converter runs continuously, each measurement starting right after the previous one.
// - Channels step local, remote 1, remote 2; each result stored per channel.
// - Each result compared with high, low, thermal limits; outcomes set status flags.
// - Alarm pin low on high or low violation or open remote diode.
// - Thermal-trip pin low whenever a result exceeds its thermal limit.
// - Configuration bit turns alarm pin into a second thermal-trip output.
// - Host writes limits and configuration; every register reads back.
// - At low rates each result is the average of sixteen measurements.
// - At 16, 32, 64 conversions per second no averaging is done.
// - Optional bus timeout abandons a stalled transfer after 25 ms, at most 32.
// - Bus timeout is off after reset until the host enables it.
// - Control bit switches between free-running conversion and standby.
// - Configuration bit selects measurement scale for results and comparisons.
// - Mask bit keeps the alarm output from asserting, except when it serves as second thermal-trip output.
// - Rate setting selects conversion rate and thereby averaging.
// - Extended scale reports high bytes in offset binary, plus 64.
// - Reading a remote low byte freezes its high byte until that is read.
// - Register pointer resets to zero, so first read returns local temperature.
module tmon_monitor
#(
  parameter int TIMEOUT_CYCLES = tmon_pkg::TIMEOUT_CYC_DFLT
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic serialClkPin,
  output logic busTimeout,
  input wire logic ptrWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic [7:0] hostData,
  output logic [7:0] rdData,
  output logic convReq,
  output logic [1:0] convChan,
  input wire logic adcValid,
  input wire logic signed [11:0] adcSample,
  input wire logic adcOpen,
  output logic thermalTripNOut,
  output logic thermalTripNOe,
  output logic secondThermalTripNOut,
  output logic secondThermalTripNOe
);
  import tmon_pkg::*;

  localparam logic [TO_W-1:0] TO_LIMIT = TO_W'(TIMEOUT_CYCLES);

  typedef struct packed {
    tmon_seq_t state;
    logic [1:0] chan;
    logic openPend;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [3:0] rate;
    logic toEn;
    logic [2:0][2:0][7:0] lim;
    logic [2:0][7:0] tempHi;
    logic [2:0][7:0] tempLo;
    logic [2:0][7:0] shadowHi;
    logic [2:0] lock;
    logic [2:0][3:0] flags;
    logic alertDrv;
    logic thermDrv;
    logic [7:0] rdData;
    logic [2:0] sclSync;
    logic sclLvl;
    logic [TO_W-1:0] toCnt;
    logic busTimeout;
  } tmon_state_t;

  tmon_state_t st_r;
  tmon_state_t st_nxt;
  tmon_smp_if smp ();
  logic [2:0] cmpHi;
  logic [2:0] cmpLo;
  logic [2:0] cmpTh;
  logic [1:0] remSel;
  logic [1:0] rdCh;
  logic isHi;
  logic isLo;
  logic [1:0] limCh;
  logic [1:0] limKind;
  logic limHit;
  logic [7:0] rdVal;
  logic anyTh;
  logic alertCond;
  logic storeEv;

  tmon_filter u_filter
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .smp(smp)
  );

  assign smp.sampleValid = (st_r.state == SQ_CONV) && adcValid;
  assign smp.sample = adcSample;
  assign smp.avgEn = st_r.rate < RATE_NOAVG;
  assign smp.extRange = st_r.cfg[CFG_EXT];
  assign storeEv = clkEn && st_r.state == SQ_WAIT && smp.stepDone && smp.resultValid;

  // Limit comparison of the fresh result against each channel's limits
  for (genvar c = 0; c < 3; c++)
  begin : g_cmp
    assign cmpHi[c] = smp.resultHi > st_r.lim[c][LIM_HIGH];
    assign cmpLo[c] = smp.resultHi < st_r.lim[c][LIM_LOW];
    assign cmpTh[c] = smp.resultHi > st_r.lim[c][LIM_THERMAL_TRIP_N];
  end

  always_comb
  begin
    st_nxt = st_r;
    remSel = st_r.cfg[CFG_R2SEL] ? CH_R2 : CH_R1;
    isHi = st_r.ptr == ADDR_REM_HI || st_r.ptr == ADDR_R2_HI;
    isLo = st_r.ptr == ADDR_REM_LO || st_r.ptr == ADDR_R2_LO;
    rdCh = (st_r.ptr == ADDR_R2_HI || st_r.ptr == ADDR_R2_LO) ? CH_R2 : remSel;
    limCh = st_r.ptr[3:2];
    limKind = st_r.ptr[1:0];
    limHit = st_r.ptr[7:4] == LIM_BANK && limCh <= CH_R2 && limKind <= LIM_THERMAL_TRIP_N;
    anyTh = 1'b0;
    alertCond = 1'b0;
    rdVal = 8'h00;
    // Read data selection
    if (st_r.ptr == ADDR_LOCAL)
      rdVal = st_r.tempHi[CH_LOCAL];
    else if (isHi)
      rdVal = st_r.lock[rdCh] ? st_r.shadowHi[rdCh] : st_r.tempHi[rdCh];
    else if (isLo)
      rdVal = st_r.tempLo[rdCh];
    else if (st_r.ptr == ADDR_STAT_A)
      rdVal = {st_r.flags[2][FL_HIGH], st_r.flags[2][FL_LOW], st_r.flags[1][FL_HIGH], st_r.flags[1][FL_LOW],
               st_r.flags[0][FL_HIGH], st_r.flags[0][FL_LOW], st_r.flags[2][FL_OPEN], st_r.flags[1][FL_OPEN]};
    else if (st_r.ptr == ADDR_STAT_B)
      rdVal = {5'h00, st_r.flags[2][FL_THERMAL_TRIP_N], st_r.flags[1][FL_THERMAL_TRIP_N], st_r.flags[0][FL_THERMAL_TRIP_N]};
    else if (st_r.ptr == ADDR_CFG_RD)
      rdVal = st_r.cfg;
    else if (st_r.ptr == ADDR_RATE)
      rdVal = {4'h0, st_r.rate};
    else if (st_r.ptr == ADDR_TOCTL)
      rdVal = {7'h00, st_r.toEn};
    else if (limHit)
      rdVal = st_r.lim[limCh][limKind];
    if (!rst_n)
    begin
      st_nxt = '0;
      st_nxt.state = SQ_IDLE;
      st_nxt.ptr = PTR_RST;
      st_nxt.cfg = CFG_RST;
      st_nxt.rate = RATE_RST;
      st_nxt.toEn = 1'b0;
      st_nxt.sclSync = 3'h7;
      st_nxt.sclLvl = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
        st_nxt.lim[i][LIM_HIGH] = LIM_HIGH_RST;
        st_nxt.lim[i][LIM_LOW] = LIM_LOW_RST;
        st_nxt.lim[i][LIM_THERMAL_TRIP_N] = LIM_THERMAL_TRIP_N_RST;
      end
    end
    else
    begin
      // Host access stays live in every sequencer state
      if (ptrWr)
      begin
        st_nxt.ptr = hostData;
      end
      else if (dataWr)
      begin
        if (st_r.ptr == ADDR_CFG_WR)
          st_nxt.cfg = hostData;
        else if (st_r.ptr == ADDR_RATE)
          st_nxt.rate = hostData[3:0];
        else if (st_r.ptr == ADDR_TOCTL)
          st_nxt.toEn = hostData[TOCTL_EN];
        else if (limHit)
          st_nxt.lim[limCh][limKind] = hostData;
      end
      if (dataRd)
      begin
        st_nxt.rdData = rdVal;
        if (isLo)
        begin
          st_nxt.lock[rdCh] = 1'b1;
          st_nxt.shadowHi[rdCh] = st_r.tempHi[rdCh];
        end
        if (isHi)
          st_nxt.lock[rdCh] = 1'b0;
      end
      // Conversion sequencer
      case (st_r.state)
        SQ_IDLE:
        begin
          if (!st_r.cfg[CFG_STBY])
            st_nxt.state = SQ_CONV;
        end
        SQ_CONV:
        begin
          if (adcValid)
          begin
            st_nxt.openPend = st_r.openPend | (adcOpen && st_r.chan != CH_LOCAL);
            st_nxt.state = SQ_WAIT;
          end
        end
        SQ_WAIT:
        begin
          if (smp.stepDone)
          begin
            if (smp.resultValid)
            begin
              st_nxt.tempHi[st_r.chan] = smp.resultHi;
              st_nxt.tempLo[st_r.chan] = (st_r.chan == CH_LOCAL) ? 8'h00 : smp.resultLo;
              st_nxt.flags[st_r.chan] = {st_r.openPend, cmpTh[st_r.chan], cmpLo[st_r.chan], cmpHi[st_r.chan]};
              st_nxt.openPend = 1'b0;
              st_nxt.chan = (st_r.chan == CH_R2) ? CH_LOCAL : st_r.chan + 2'h1;
              st_nxt.state = st_r.cfg[CFG_STBY] ? SQ_IDLE : SQ_CONV;
            end
            else
            begin
              st_nxt.state = SQ_CONV;
            end
          end
        end
        default:
        begin
          st_nxt.state = SQ_IDLE;
        end
      endcase
      // Alarm pins follow the flags and the current configuration
      for (int i = 0; i < 3; i++)
      begin
        anyTh = anyTh | st_nxt.flags[i][FL_THERMAL_TRIP_N];
        alertCond = alertCond | st_nxt.flags[i][FL_HIGH] | st_nxt.flags[i][FL_LOW] | st_nxt.flags[i][FL_OPEN];
      end
      st_nxt.thermDrv = anyTh;
      st_nxt.alertDrv = st_nxt.cfg[CFG_ALT] ? anyTh : (alertCond && !st_nxt.cfg[CFG_MASK]);
      // Serial clock low-time watchdog
      st_nxt.sclSync = {st_r.sclSync[1:0], serialClkPin};
      if (st_r.sclSync[2] == st_r.sclSync[1])
        st_nxt.sclLvl = st_r.sclSync[2];
      st_nxt.busTimeout = 1'b0;
      if (!st_r.toEn || st_r.sclLvl)
      begin
        st_nxt.toCnt = '0;
      end
      else if (st_r.toCnt != TO_LIMIT)
      begin
        st_nxt.toCnt = st_r.toCnt + TO_W'(1);
        st_nxt.busTimeout = st_r.toCnt == TO_LIMIT - TO_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clkEn)
    begin
      st_r <= st_nxt;
    end
  end

  assign busTimeout = st_r.busTimeout;
  assign rdData = st_r.rdData;
  assign convReq = st_r.state == SQ_CONV;
  assign convChan = st_r.chan;
  assign thermalTripNOut = 1'b0;
  assign thermalTripNOe = st_r.thermDrv;
  assign secondThermalTripNOut = 1'b0;
  assign secondThermalTripNOe = st_r.alertDrv;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lo_read;
    clkEn && dataRd && isLo;
  endsequence

  sequence s_hi_read_locked;
    clkEn && dataRd && isHi && st_r.lock[rdCh];
  endsequence

  property p_ptr_rst;
    $rose(rst_n) |-> st_r.ptr == PTR_RST && st_r.toEn == 1'b0;
  endproperty
  a_ptr_rst: assert property (p_ptr_rst) else $error("pointer or timeout enable not reset");

  property p_to_off;
    busTimeout |-> $past(st_r.toEn) && !$past(st_r.sclLvl);
  endproperty
  a_to_off: assert property (p_to_off) else $error("timeout while disabled or clock high");

  property p_to_fire;
    clkEn && st_r.toEn && !st_r.sclLvl && st_r.toCnt == TO_LIMIT - TO_W'(1) |=> busTimeout;
  endproperty
  a_to_fire: assert property (p_to_fire) else $error("timeout missed at limit");

  property p_run;
    storeEv && !st_r.cfg[CFG_STBY] |=> convReq;
  endproperty
  a_run: assert property (p_run) else $error("next conversion not started");

  property p_stby;
    clkEn && st_r.state == SQ_IDLE && st_r.cfg[CFG_STBY] |=> !convReq;
  endproperty
  a_stby: assert property (p_stby) else $error("conversion during standby");

  property p_store;
    storeEv |=> st_r.tempHi[$past(st_r.chan)] == $past(smp.resultHi) && st_r.chan != $past(st_r.chan);
  endproperty
  a_store: assert property (p_store) else $error("result not stored or channel not stepped");

  property p_flag;
    storeEv |=> st_r.flags[$past(st_r.chan)][FL_THERMAL_TRIP_N] == $past(cmpTh[st_r.chan]);
  endproperty
  a_flag: assert property (p_flag) else $error("thermal flag not updated");

  property p_thermal_trip_n_pin;
    $changed(thermalTripNOe) |-> $past(storeEv);
  endproperty
  a_thermal_trip_n_pin: assert property (p_thermal_trip_n_pin) else $error("thermal pin moved without a result");

  property p_alt;
    st_r.cfg[CFG_ALT] |-> secondThermalTripNOe == thermalTripNOe;
  endproperty
  a_alt: assert property (p_alt) else $error("second thermal output differs");

  property p_mask;
    secondThermalTripNOe && !st_r.cfg[CFG_ALT] |-> !st_r.cfg[CFG_MASK];
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm asserted");

  property p_cfg_wr;
    clkEn && dataWr && !ptrWr && st_r.ptr == ADDR_CFG_WR |=> st_r.cfg == $past(hostData);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("configuration write lost");

  property p_lock;
    s_lo_read |=> st_r.lock[$past(rdCh)] && st_r.shadowHi[$past(rdCh)] == $past(st_r.tempHi[rdCh]);
  endproperty
  a_lock: assert property (p_lock) else $error("high byte not frozen");

  property p_shadow_rd;
    s_hi_read_locked |=> rdData == $past(st_r.shadowHi[rdCh]);
  endproperty
  a_shadow_rd: assert property (p_shadow_rd) else $error("frozen high byte not returned");
endmodule : tmon_monitor

// File: tmon_host.sv
// Host-side model of the two-wire front end: register strobes and serial clock level.
// Assumes the monitor takes strobes on sys_clk rising edges; serial clock idles high.
module tmon_host
(
  input logic sys_clk,
  input logic [7:0] rdData,
  output logic ptrWr,
  output logic dataWr,
  output logic dataRd,
  output logic [7:0] hostData,
  output logic serialClkPin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    ptrWr = 1'b0;
    dataWr = 1'b0;
    dataRd = 1'b0;
    hostData = 8'h00;
    serialClkPin = 1'b1;
  end

  task automatic set_ptr(input logic [7:0] p);
    @(posedge sys_clk);
    ptrWr <= 1'b1;
    hostData <= p;
    @(posedge sys_clk);
    ptrWr <= 1'b0;
  endtask : set_ptr

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    set_ptr(p);
    dataWr <= 1'b1;
    hostData <= d;
    @(posedge sys_clk);
    dataWr <= 1'b0;
    hostData <= ~d;
  endtask : wr

  task automatic rd_cur(output logic [7:0] d);
    @(posedge sys_clk);
    dataRd <= 1'b1;
    @(posedge sys_clk);
    dataRd <= 1'b0;
    #1;
    d = rdData;
  endtask : rd_cur

  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    set_ptr(p);
    hostData <= ~p;
    rd_cur(d);
  endtask : rd

  // Stall the transfer with the serial clock held low
  task automatic sclk_low(input int n);
    @(posedge sys_clk);
    serialClkPin <= 1'b0;
    repeat (n) @(posedge sys_clk);
    serialClkPin <= 1'b1;
  endtask : sclk_low
endmodule : tmon_host

// File: tb.sv
// Self-checking bench of the temperature monitor, with a host model and an ADC stand-in.
// Assumes one 100 MHz clock and a shortened bus timeout.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmon_pkg::*;
  localparam int TO_CYC = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic adcValid = 1'b0;
  logic signed [11:0] adcSample = 12'sh000;
  logic adcOpen = 1'b0;
  logic clkEn = 1'b1;
  logic ptrWr, dataWr, dataRd, serialClkPin, busTimeout, convReq;
  logic [7:0] hostData, rdData;
  logic [1:0] convChan;
  logic tOut, tOe, aOut, aOe;
  int badCount = 0;
  int nChecks = 0;
  int cycles = 0;
  int toCount = 0;
  int toAt = 0;
  wire thermalTripN = tOe ? tOut : 1'b1;
  wire secondThermalTripN = aOe ? aOut : 1'b1;

  always #5 sys_clk = ~sys_clk;

  tmon_monitor #(.TIMEOUT_CYCLES(TO_CYC)) tmon_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .serialClkPin(serialClkPin), .busTimeout(busTimeout), .ptrWr(ptrWr), .dataWr(dataWr), .dataRd(dataRd),
    .hostData(hostData), .rdData(rdData), .convReq(convReq), .convChan(convChan), .adcValid(adcValid),
    .adcSample(adcSample), .adcOpen(adcOpen), .thermalTripNOut(tOut), .thermalTripNOe(tOe),
    .secondThermalTripNOut(aOut), .secondThermalTripNOe(aOe));

  tmon_host tmon_host_inst (.sys_clk(sys_clk), .rdData(rdData), .ptrWr(ptrWr), .dataWr(dataWr),
    .dataRd(dataRd), .hostData(hostData), .serialClkPin(serialClkPin));

  task automatic completeRun;
    $display("TB: checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : completeRun

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (busTimeout === 1'b1)
    begin
      toCount <= toCount + 1;
      toAt <= cycles;
    end
    if (cycles == 20000)
    begin
      badCount++;
      completeRun;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rg(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    tmon_host_inst.rd(p, v);
    chk(v, e);
  endtask : rg

  task automatic do_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // Answer one conversion request; returns once the sample has been filtered and any result stored
  task automatic samp(input logic [1:0] ch, input int q, input logic op);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    while (convReq !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({7'h00, convReq}, 8'h01);
    chk({6'h00, convChan}, {6'h00, ch});
    @(posedge sys_clk);
    adcValid <= 1'b1;
    adcSample <= q[11:0];
    adcOpen <= op;
    @(posedge sys_clk);
    adcValid <= 1'b0;
    adcSample <= ~q[11:0];
    adcOpen <= ~op;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : samp

  task automatic t_avg;
    logic [7:0] v;
    do_reset;
    for (int i = 0; i < 16; i++)
      samp(CH_LOCAL, (i == 7) ? 164 : 100, 1'b0);
    tmon_host_inst.rd_cur(v);
    chk(v, 8'h1a);
    rg(ADDR_CFG_RD, CFG_RST);
    rg(ADDR_RATE, {4'h0, RATE_RST});
    rg(8'h42, LIM_THERMAL_TRIP_N_RST);
    rg(8'h7f, 8'h00);
    $display("t_avg done");
  endtask : t_avg

  task automatic t_fast;
    do_reset;
    tmon_host_inst.wr(ADDR_RATE, {4'h0, RATE_NOAVG});
    samp(CH_LOCAL, 164, 1'b0);
    rg(ADDR_LOCAL, 8'h29);
    samp(CH_R1, 122, 1'b0);
    samp(CH_R2, 363, 1'b0);
    rg(ADDR_REM_LO, 8'h80);
    rg(ADDR_REM_HI, 8'h1e);
    rg(ADDR_R2_LO, 8'hc0);
    rg(ADDR_R2_HI, 8'h5a);
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h08);
    rg(ADDR_REM_HI, 8'h5a);
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h00);
    rg(ADDR_REM_LO, 8'h80);
    samp(CH_LOCAL, 164, 1'b0);
    samp(CH_R1, 200, 1'b0);
    rg(ADDR_REM_HI, 8'h1e);
    rg(ADDR_REM_HI, 8'h32);
    $display("t_fast done");
  endtask : t_fast

  task automatic t_ext;
    do_reset;
    tmon_host_inst.wr(ADDR_RATE, {4'h0, RATE_NOAVG});
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h04);
    samp(CH_LOCAL, 200, 1'b0);
    rg(ADDR_LOCAL, 8'h72);
    rg(ADDR_STAT_A, 8'h08);
    samp(CH_R1, -40, 1'b0);
    rg(ADDR_REM_HI, 8'h36);
    $display("t_ext done");
  endtask : t_ext

  task automatic t_alarm;
    do_reset;
    tmon_host_inst.wr(ADDR_RATE, {4'h0, RATE_NOAVG});
    tmon_host_inst.wr(8'h40, 8'h40);
    tmon_host_inst.wr(8'h49, 8'h14);
    samp(CH_LOCAL, 280, 1'b0);
    chk({7'h00, secondThermalTripN}, 8'h00);
    chk({7'h00, thermalTripN}, 8'h01);
    samp(CH_R1, 400, 1'b1);
    chk({7'h00, thermalTripN}, 8'h00);
    samp(CH_R2, 40, 1'b0);
    rg(ADDR_STAT_A, 8'h69);
    rg(ADDR_STAT_B, 8'h02);
    tmon_host_inst.wr(8'h40, 8'h7f);
    samp(CH_LOCAL, 280, 1'b0);
    rg(ADDR_STAT_A, 8'h61);
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h80);
    samp(CH_R1, 400, 1'b1);
    chk({7'h00, secondThermalTripN}, 8'h01);
    tmon_host_inst.wr(ADDR_CFG_WR, 8'ha0);
    samp(CH_R2, 40, 1'b0);
    chk({7'h00, secondThermalTripN}, 8'h00);
    $display("t_alarm done");
  endtask : t_alarm

  task automatic t_stby;
    do_reset;
    tmon_host_inst.wr(ADDR_RATE, {4'h0, RATE_NOAVG});
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h40);
    samp(CH_LOCAL, 164, 1'b0);
    repeat (10) @(posedge sys_clk);
    #1;
    chk({7'h00, convReq}, 8'h00);
    rg(ADDR_LOCAL, 8'h29);
    tmon_host_inst.wr(8'h44, 8'h33);
    rg(8'h44, 8'h33);
    chk({7'h00, convReq}, 8'h00);
    tmon_host_inst.wr(ADDR_CFG_WR, 8'h00);
    samp(CH_R1, 122, 1'b0);
    rg(ADDR_REM_HI, 8'h1e);
    $display("t_stby done");
  endtask : t_stby

  // Clock enable low: a sample offered while frozen must be ignored
  task automatic t_hold;
    do_reset;
    tmon_host_inst.wr(ADDR_RATE, {4'h0, RATE_NOAVG});
    @(posedge sys_clk);
    clkEn <= 1'b0;
    adcValid <= 1'b1;
    adcSample <= 12'sh0a4;
    repeat (4) @(posedge sys_clk);
    adcValid <= 1'b0;
    clkEn <= 1'b1;
    #1;
    chk({7'h00, convReq}, 8'h01);
    rg(ADDR_LOCAL, 8'h00);
    samp(CH_LOCAL, 164, 1'b0);
    rg(ADDR_LOCAL, 8'h29);
    $display("t_hold done");
  endtask : t_hold

  task automatic t_tmo;
    int t0;
    int c0;
    do_reset;
    c0 = toCount;
    tmon_host_inst.sclk_low(80);
    chk(8'(toCount - c0), 8'h00);
    tmon_host_inst.wr(ADDR_TOCTL, 8'h01);
    t0 = cycles;
    tmon_host_inst.sclk_low(80);
    repeat (2) @(posedge sys_clk);
    chk(8'(toCount - c0), 8'h01);
    chk({7'h00, (toAt - t0 >= TO_CYC) && (toAt - t0 <= TO_CYC * 32 / 25)}, 8'h01);
    $display("t_tmo done");
  endtask : t_tmo

  initial
  begin
    t_avg;
    t_fast;
    t_ext;
    t_alarm;
    t_stby;
    t_hold;
    t_tmo;
    completeRun;
  end
endmodule : tb
